// File: status_pkg.sv
// Constants of the monitor interrupt status block and the VID change detector.
// Assumes a 25 MHz system clock and a register port driven by the serial bus front end.
package status_pkg;
    // Register offsets
    localparam logic [7:0] STATUS_FIRST_ADDR = 8'h41;
    localparam logic [7:0] STATUS_SECOND_ADDR = 8'h42;
    // Reset values
    localparam logic [7:0] STATUS_FIRST_RESET = 8'h00;
    localparam logic [7:0] STATUS_SECOND_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
    // First status register field positions
    localparam int SUPPLY_2V5_BIT = 0;
    localparam int PROC_CORE_SUPPLY_BIT = 1;
    localparam int OWN_SUPPLY_BIT = 2;
    localparam int SUPPLY_5V_BIT = 3;
    localparam int REMOTE_ONE_TEMP_BIT = 4;
    localparam int LOCAL_TEMP_BIT = 5;
    localparam int REMOTE_TWO_TEMP_BIT = 6;
    localparam int SUMMARY_BIT = 7;
    // Second status register field positions
    localparam int TWELVE_OR_CODE_BIT = 0;
    localparam int OVERTEMP_BIT = 1;
    localparam int FIRST_FAN_BIT = 2;
    localparam int FOURTH_FAN_BIT = 5;
    localparam int FIRST_DIODE_BIT = 6;
    localparam int SECOND_DIODE_BIT = 7;
    // Timing
    localparam int CLK_FREQ_KHZ = 25000;
    localparam int VID_WINDOW_NS = 11000;
    localparam int VID_WINDOW_CYCLES = (VID_WINDOW_NS * CLK_FREQ_KHZ) / 1000000;
endpackage

// File: vid_change_detect.sv
// VID code change detector: compares the six VID levels with a snapshot taken
// one window earlier.
// Assumes VID inputs already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module vid_change_detect
    import status_pkg::*;
#(
    parameter int WINDOW_CYCLES = VID_WINDOW_CYCLES
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic enable, // Detection enabled
    input wire logic [5:0] vid_code, // Current VID levels
    output logic change_pulse // One cycle when code differs
);
    logic [8:0] count_q;
    logic [8:0] count_d;
    logic [5:0] snap_q;
    logic [5:0] snap_d;
    logic change_q;
    logic change_d;
    logic tick;

    // Window counter, snapshot and compare
    always_comb begin
        tick = (count_q == 9'(WINDOW_CYCLES - 1));
        count_d = tick ? 9'h000 : count_q + 9'h001;
        snap_d = tick ? vid_code : snap_q;
        change_d = tick && enable && (vid_code != snap_q);
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= 9'h000;
            snap_q <= 6'h00;
            change_q <= 1'b0;
        end else begin
            count_q <= count_d;
            snap_q <= enable ? snap_d : vid_code;
            change_q <= change_d;
        end
    end

    assign change_pulse = change_q;
endmodule
`default_nettype wire

// File: monitor_interrupt_status.sv
// Interrupt status registers of the hardware monitor: latching of limit events,
// clear-on-read with condition check, and the summary bit.
// Assumes measurement values, limits and configuration come from the
// measurement core, and reads arrive as one-cycle strobes from the bus front end.
`timescale 1ns/1ps
`default_nettype none
module monitor_interrupt_status
    import status_pkg::*;
#(
    parameter int VID_WINDOW = VID_WINDOW_CYCLES,
    parameter int FAN_COUNT_WIDTH = 16
) (
    input wire logic clk, // System clock, 25 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic rd_strobe, // One-cycle register read
    input wire logic [7:0] rd_addr, // Read address
    output logic [7:0] rd_data, // Read data, registered
    input wire logic wr_strobe, // One-cycle register write
    input wire logic [7:0] wr_addr, // Write address
    input wire logic [7:0] wr_data, // Write data
    input wire logic [39:0] volt_value, // 2.5V, core, own, 5V, 12V readings
    input wire logic [39:0] volt_low, // Low limits, same order
    input wire logic [39:0] volt_high, // High limits, same order
    input wire logic [23:0] temp_value, // Remote one, local, remote two
    input wire logic [23:0] temp_low, // Low temperature limits
    input wire logic [23:0] temp_high, // High temperature limits
    input wire logic [23:0] thermal_limit_pin_limit, // Overtemperature limits
    input wire logic [7:0] temperature_hysteresis, // Overtemperature hysteresis
    input wire logic [4*FAN_COUNT_WIDTH-1:0] tach_count, // Four fan counts
    input wire logic [4*FAN_COUNT_WIDTH-1:0] tach_limit, // Four minimum limits
    input wire logic [2:0] pwm_off, // PWM one to three off
    input wire logic timer_select, // Thermal pin timer input selected
    input wire logic [7:0] assert_time, // Measured assertion time
    input wire logic [7:0] assert_limit, // Assertion time limit
    input wire logic first_diode_fault, // First remote diode open or short
    input wire logic second_diode_fault, // Second remote diode open or short
    input wire logic shared_pin_select, // 0 twelve volt, 1 sixth VID
    input wire logic [4:0] vid_code, // VID levels zero to four
    input wire logic sixth_voltage_id_input, // VID level five on shared pin
    output logic summary_out_of_limit, // First register bit 7
    output logic vid_change_alert // One-cycle VID change pulse
);
    logic [7:0] first_q;
    logic [7:0] first_d;
    logic [7:0] second_q;
    logic [7:0] second_d;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic [7:0] first_cond;
    logic [7:0] second_cond;
    logic [7:0] second_clearable;
    logic read_first;
    logic read_second;
    logic vid_change;
    logic [5:0] vid_all;
    logic write_ignored;

    // Signed or unsigned window check of one reading
    function automatic logic out_of_limit(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi, input logic is_signed);
        logic above;
        logic below;
        above = 1'b0;
        below = 1'b0;
        if (is_signed) begin
            above = $signed(v) > $signed(hi);
            below = $signed(v) <= $signed(lo);
        end else begin
            above = v > hi;
            below = v <= lo;
        end
        return above | below;
    endfunction

    // Overtemperature cleared state: reading below limit minus hysteresis
    function automatic logic below_release(input logic [7:0] v, input logic [7:0] lim,
                                           input logic [7:0] hyst);
        logic signed [8:0] thr;
        thr = 9'($signed(lim)) - 9'($signed({1'b0, hyst}));
        return 9'($signed(v)) < thr;
    endfunction

    // VID change detector on the six-bit code
    assign vid_all = {sixth_voltage_id_input & shared_pin_select, vid_code};

    vid_change_detect #(
        .WINDOW_CYCLES(VID_WINDOW)
    ) u_vid (
        .clk(clk),
        .rst(rst),
        .enable(shared_pin_select),
        .vid_code(vid_all),
        .change_pulse(vid_change)
    );

    // Present conditions of the first register
    always_comb begin
        first_cond = 8'h00;
        for (int i = 0; i < 4; i++) begin
            first_cond[SUPPLY_2V5_BIT + i] = out_of_limit(volt_value[8*i +: 8],
                volt_low[8*i +: 8], volt_high[8*i +: 8], 1'b0);
        end
        for (int t = 0; t < 3; t++) begin
            first_cond[REMOTE_ONE_TEMP_BIT + t] = out_of_limit(temp_value[8*t +: 8],
                temp_low[8*t +: 8], temp_high[8*t +: 8], 1'b1);
        end
    end

    // Present conditions and clear permission of the second register
    always_comb begin
        second_cond = 8'h00;
        second_clearable = 8'hFF;
        if (shared_pin_select) begin
            second_cond[TWELVE_OR_CODE_BIT] = vid_change;
        end else begin
            second_cond[TWELVE_OR_CODE_BIT] = out_of_limit(volt_value[39:32],
                volt_low[39:32], volt_high[39:32], 1'b0);
        end
        for (int t = 0; t < 3; t++) begin
            if ($signed(temp_value[8*t +: 8]) > $signed(thermal_limit_pin_limit[8*t +: 8])) begin
                second_cond[OVERTEMP_BIT] = 1'b1;
            end
            if (!below_release(temp_value[8*t +: 8], thermal_limit_pin_limit[8*t +: 8],
                               temperature_hysteresis)) begin
                second_clearable[OVERTEMP_BIT] = 1'b0;
            end
        end
        for (int f = 0; f < 3; f++) begin
            second_cond[FIRST_FAN_BIT + f] = !pwm_off[f] &&
                (tach_count[FAN_COUNT_WIDTH*f +: FAN_COUNT_WIDTH] >
                 tach_limit[FAN_COUNT_WIDTH*f +: FAN_COUNT_WIDTH]);
        end
        if (timer_select) begin
            second_cond[FOURTH_FAN_BIT] = assert_time > assert_limit;
        end else begin
            second_cond[FOURTH_FAN_BIT] = !pwm_off[2] &&
                (tach_count[FAN_COUNT_WIDTH*3 +: FAN_COUNT_WIDTH] >
                 tach_limit[FAN_COUNT_WIDTH*3 +: FAN_COUNT_WIDTH]);
        end
        second_cond[FIRST_DIODE_BIT] = first_diode_fault;
        second_cond[SECOND_DIODE_BIT] = second_diode_fault;
    end

    // Read decode; writes have no effect on the flags
    assign read_first = rd_strobe && (rd_addr == STATUS_FIRST_ADDR);
    assign read_second = rd_strobe && (rd_addr == STATUS_SECOND_ADDR);
    assign write_ignored = wr_strobe && (wr_addr != 8'h00) && (wr_data != 8'h00);

    // Next flag values: a new event wins over a clear in the same cycle
    always_comb begin
        first_d = first_cond | (first_q & ~({8{read_first}} & ~first_cond));
        first_d[SUMMARY_BIT] = 1'b0;
        second_d = second_cond |
            (second_q & ~({8{read_second}} & ~second_cond & second_clearable));
    end

    // Read data captures the flags before the clear
    always_comb begin
        rd_data_d = rd_data_q;
        if (read_first) begin
            rd_data_d = {|second_q, first_q[6:0]};
        end else if (read_second) begin
            rd_data_d = second_q;
        end else if (rd_strobe) begin
            rd_data_d = UNMAPPED_READ_VALUE;
        end
    end

    // Flag and read data registers
    always_ff @(posedge clk) begin
        if (rst) begin
            first_q <= STATUS_FIRST_RESET;
            second_q <= STATUS_SECOND_RESET;
            rd_data_q <= UNMAPPED_READ_VALUE;
        end else begin
            first_q <= first_d;
            second_q <= second_d;
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;
    assign summary_out_of_limit = |second_q;
    assign vid_change_alert = vid_change;
endmodule
`default_nettype wire

// File: status_properties.sv
// Assertions on the status block ports.
// Assumes one-cycle read strobes answered on the next edge.
`timescale 1ns/1ps
`default_nettype none
module status_properties
    import status_pkg::*;
#(
    parameter int FAN_COUNT_WIDTH = 16
) (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic rd_strobe, // Read
    input wire logic [7:0] rd_addr, // Address
    input wire logic [7:0] rd_data, // Data
    input wire logic [39:0] volt_value, // Volts
    input wire logic [39:0] volt_high, // Highs
    input wire logic [23:0] temp_value, // Temps
    input wire logic [23:0] temp_high, // Highs
    input wire logic [23:0] thermal_limit_pin_limit, // Overtemp
    input wire logic [4*FAN_COUNT_WIDTH-1:0] tach_count, // Counts
    input wire logic [4*FAN_COUNT_WIDTH-1:0] tach_limit, // Limits
    input wire logic [2:0] pwm_off, // PWM off
    input wire logic shared_pin_select, // VID mode
    input wire logic summary_out_of_limit, // Summary
    input wire logic vid_change_alert // Alert
);
    // Read decodes
    wire rd1 = rd_strobe && rd_addr == STATUS_FIRST_ADDR;
    wire rd2 = rd_strobe && rd_addr == STATUS_SECOND_ADDR;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Reset read data, flags seen by the first read after their cause, summary bit, no alert in volt mode
    property p_reset; $fell(rst) |-> rd_data == 8'h00; endproperty
    a_reset: assert property (p_reset) else $error("data not clear");
    property p_volt; volt_value[7:0] > volt_high[7:0] ##1 rd1 |=> rd_data[0]; endproperty
    a_volt: assert property (p_volt) else $error("volt flag");
    property p_temp;
        $signed(temp_value[15:8]) > $signed(temp_high[15:8]) ##1 rd1 |=> rd_data[5];
    endproperty
    a_temp: assert property (p_temp) else $error("temp flag");
    property p_sum; rd1 |=> rd_data[7] == $past(summary_out_of_limit); endproperty
    a_sum: assert property (p_sum) else $error("summary bit");
    property p_ovt;
        $signed(temp_value[7:0]) > $signed(thermal_limit_pin_limit[7:0]) ##1 rd2 |=> rd_data[1];
    endproperty
    a_ovt: assert property (p_ovt) else $error("overtemp flag");
    property p_fan;
        tach_count[FAN_COUNT_WIDTH-1:0] > tach_limit[FAN_COUNT_WIDTH-1:0] && !pwm_off[0]
            ##1 rd2 |=> rd_data[2];
    endproperty
    a_fan: assert property (p_fan) else $error("fan flag");
    property p_vid; vid_change_alert ##1 !rd_strobe ##1 rd2 |=> rd_data[0]; endproperty
    a_vid: assert property (p_vid) else $error("code change flag");
    property p_vid_off; !shared_pin_select [*3] |=> !vid_change_alert; endproperty
    a_vid_off: assert property (p_vid_off) else $error("alert in volt mode");
endmodule
bind monitor_interrupt_status status_properties #(.FAN_COUNT_WIDTH(FAN_COUNT_WIDTH))
    i_status_properties (.*);
`default_nettype wire

// File: host_model.sv
// Bus host model issuing register reads and writes.
// Assumes strobes sampled on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk, // Clock
    input wire logic [7:0] rd_data, // Read data
    output logic rd_strobe = 1'b0, // Read
    output logic [7:0] rd_addr = 8'h00, // Read address
    output logic wr_strobe = 1'b0, // Write
    output logic [7:0] wr_addr = 8'h00, // Write address
    output logic [7:0] wr_data = 8'h00 // Write data
);
    // One read; released address shows junk
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        rd_strobe <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_strobe <= 1'b0;
        rd_addr <= ~a;
        @(posedge clk);
        d = rd_data; // Stable here: no strobe was sampled at this edge
    endtask
    // One write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_strobe <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_strobe <= 1'b0;
        wr_data <= ~d;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// File: monitor_interrupt_status_tb.sv
// Testbench of the status block driven through the host model.
// Assumes a VID window shortened to 5 cycles.
`timescale 1ns/1ps
`default_nettype none
module monitor_interrupt_status_tb;
    import status_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd_strobe, wr_strobe, summary_out_of_limit, vid_change_alert;
    logic [7:0] rd_addr, rd_data, wr_addr, wr_data, assert_time = 8'h00, assert_limit = 8'h10;
    logic [39:0] volt_value = 40'h8080808080, volt_low = {5{8'h10}}, volt_high = {5{8'hF0}};
    logic [23:0] temp_value = 24'h0, temp_low = {3{8'h81}}, temp_high = {3{8'h7F}};
    logic [23:0] thermal_limit_pin_limit = {3{8'h7F}};
    logic [7:0] temperature_hysteresis = 8'h08;
    logic [63:0] tach_count = 64'h0, tach_limit = {4{16'h0100}};
    logic [2:0] pwm_off = 3'b000;
    logic timer_select = 1'b0, first_diode_fault = 1'b0, second_diode_fault = 1'b0;
    logic shared_pin_select = 1'b0, sixth_voltage_id_input = 1'b0;
    logic [4:0] vid_code = 5'h00;
    int n_mismatch = 0;
    int checks = 0;
    monitor_interrupt_status #(.VID_WINDOW(5)) i_monitor_interrupt_status (.*);
    host_model i_host_model (.*);
    initial begin
        forever #20 clk = ~clk;
    end
    // Compare one value
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    // Read a register and compare
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host_model.rd(a, d);
        cmp($sformatf("reg %h", a), exp, d);
    endtask
    // Reset values, unmapped read, ignored writes
    task automatic t_reset;
        rc(STATUS_FIRST_ADDR, 8'h00);
        rc(STATUS_SECOND_ADDR, 8'h00);
        rc(8'h43, 8'h00);
        i_host_model.wr(STATUS_FIRST_ADDR, 8'hFF);
        i_host_model.wr(STATUS_SECOND_ADDR, 8'hFF);
        rc(STATUS_FIRST_ADDR, 8'h00);
        rc(STATUS_SECOND_ADDR, 8'h00);
    endtask
    // Limit flags, boundaries and clear only once gone
    task automatic t_limits;
        volt_value <= 40'h10F08010F1;
        temp_value <= 24'h7F00F0;
        temp_low <= 24'h8181F6;
        @(posedge clk);
        rc(STATUS_FIRST_ADDR, 8'h93);
        rc(STATUS_FIRST_ADDR, 8'h93);
        volt_value <= 40'h8080808080;
        temp_value <= 24'h0;
        rc(STATUS_FIRST_ADDR, 8'h93);
        rc(STATUS_FIRST_ADDR, 8'h80);
        rc(STATUS_SECOND_ADDR, 8'h01);
        rc(STATUS_FIRST_ADDR, 8'h00);
    endtask
    // Second register sources and overtemperature hysteresis
    task automatic t_second;
        pwm_off <= 3'b010;
        tach_count <= 64'h0000_0000_0200_0101;
        timer_select <= 1'b1;
        assert_time <= 8'h11;
        temp_value <= 24'h500000;
        thermal_limit_pin_limit <= 24'h407F7F;
        first_diode_fault <= 1'b1;
        second_diode_fault <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        cmp("summary", 8'h01, {7'h00, summary_out_of_limit});
        rc(STATUS_FIRST_ADDR, 8'h80);
        tach_count <= 64'h0;
        assert_time <= 8'h00;
        temp_value <= 24'h3C0000;
        first_diode_fault <= 1'b0;
        second_diode_fault <= 1'b0;
        rc(STATUS_SECOND_ADDR, 8'hE6);
        rc(STATUS_SECOND_ADDR, 8'h02);
        temp_value <= 24'h370000;
        rc(STATUS_SECOND_ADDR, 8'h02);
        rc(STATUS_SECOND_ADDR, 8'h00);
    endtask
    // Fan four against the third PWM, fan one count equal to limit
    task automatic t_fan4;
        timer_select <= 1'b0;
        pwm_off <= 3'b100;
        tach_count <= 64'h0101_0000_0000_0000;
        @(posedge clk);
        rc(STATUS_SECOND_ADDR, 8'h00);
        pwm_off <= 3'b000;
        tach_count <= 64'h0101_0000_0000_0100;
        @(posedge clk);
        rc(STATUS_SECOND_ADDR, 8'h20);
        tach_count <= 64'h0;
        rc(STATUS_SECOND_ADDR, 8'h20);
        rc(STATUS_SECOND_ADDR, 8'h00);
    endtask
    // VID change on the shared pin
    task automatic t_vid;
        logic seen;
        seen = 1'b0;
        shared_pin_select <= 1'b1;
        repeat (10) @(posedge clk);
        sixth_voltage_id_input <= 1'b1;
        repeat (20) begin
            @(posedge clk);
            #1 if (vid_change_alert === 1'b1) seen = 1'b1;
            if (seen) break;
        end
        cmp("alert", 8'h01, {7'h00, seen});
        @(posedge clk);
        rc(STATUS_SECOND_ADDR, 8'h01);
        rc(STATUS_SECOND_ADDR, 8'h00);
    endtask
    // Verdict and end of run
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_limits;
        t_second;
        t_fan4;
        t_vid;
        summarize;
    end
    // Watchdog
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        summarize;
    end
endmodule
`default_nettype wire
